/* dcs_config_sync_sequencer.sv */
`timescale 1ns/1ps
module dcs_config_sync_sequencer (
    input wire logic clk,
    input wire logic rstn,
    input wire dcs_pkg::dcs_bus_t bus,
    output logic [dcs_pkg::DW-1:0] rdata,
    input wire dcs_pkg::dcs_pins_t pins,
    input wire logic [dcs_pkg::DW-1:0] alarmEvents,
    input wire logic [dcs_pkg::DW-1:0] patternResults,
    input wire logic [7:0] tempData,
    input wire logic [2:0] loopFilterVolt,
    output dcs_pkg::dcs_sync_t syncOut,
    output logic [dcs_pkg::DW-1:0] mainCtrl,
    output logic [dcs_pkg::DW-1:0] vcoTune,
    output logic irq
);
    typedef struct packed {
        logic [15:0] mainCtl;
        logic [15:0] parity;
        logic [15:0] shutoff;
        logic [15:0] current;
        logic [15:0] pll;
        logic [15:0] vco;
        logic [15:0] refSel;
        logic [15:0] corrSrc;
        logic [15:0] mixSrc;
        logic [15:0] fifoSrc;
        logic [dcs_pkg::NIRQ-1:0] irqMask;
        logic [dcs_pkg::NIRQ-1:0] irqStat;
        logic [15:0] rdata;
        dcs_pkg::dcs_sync_t sync;
    } dcs_state_t;

    dcs_state_t s_q;
    dcs_state_t s_d;

    logic [4:0] pinLevel;
    logic [4:0] pinRise;
    logic [15:0] alarmFlags;
    logic [15:0] alarmClr;
    logic alarmWrite;
    logic sifSyncRise;
    logic autoWrite;
    logic [dcs_pkg::NIRQ-1:0] irqEvt;

    // Pins come from other clock domains
    dcs_sync_in #(
        .W(5)
    ) u_pins (
        .clk(clk),
        .rstn(rstn),
        .pinIn({pins.inputStrobe, pins.outputStrobe, pins.syncPinPair,
                pins.framePinPair, pins.txGatePin}),
        .level(pinLevel),
        .rise(pinRise)
    );

    assign alarmWrite = bus.wr && (bus.addr == dcs_pkg::OFS_ALARM);
    // Only a write of zero clears; other values leave flags alone
    assign alarmClr = (alarmWrite && bus.wdata == dcs_pkg::RST_ZERO) ? 16'hffff : 16'h0000;

    dcs_sticky #(
        .W(16)
    ) u_alarms (
        .clk(clk),
        .rstn(rstn),
        .setBits(alarmEvents & dcs_pkg::ALM_IMPL),
        .clrBits(alarmClr),
        .flags(alarmFlags)
    );

    // Soft trigger fires only on a 0 to 1 change of the bit
    assign sifSyncRise = bus.wr && (bus.addr == dcs_pkg::OFS_MIXSYNC)
        && bus.wdata[dcs_pkg::BIT_SIF_SYNC] && !s_q.mixSrc[dcs_pkg::BIT_SIF_SYNC];

    // Writes to correction or phase offsets auto-sync the correction block only
    assign autoWrite = bus.wr && (bus.addr >= dcs_pkg::OFS_AUTO_FIRST)
        && (bus.addr <= dcs_pkg::OFS_AUTO_LAST);

    always_comb
    begin
        s_d = s_q;
        s_d.rdata = '0;

        // Register writes; read-only and alarm offsets take none
        if (bus.wr)
        begin
            if (bus.addr == dcs_pkg::OFS_MAIN)
                s_d.mainCtl = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_PARITY)
                s_d.parity = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_SHUTOFF)
                s_d.shutoff = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_CURRENT)
                s_d.current = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_PLL)
                s_d.pll = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_VCO)
                s_d.vco = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_REFSEL)
                s_d.refSel = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_CORRSYNC)
                s_d.corrSrc = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_MIXSYNC)
                s_d.mixSrc = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_FIFOSYNC)
                s_d.fifoSrc = bus.wdata;
            else if (bus.addr == dcs_pkg::OFS_IRQMASK)
                s_d.irqMask = bus.wdata[dcs_pkg::NIRQ-1:0];
        end

        // Read data valid the cycle after the strobe
        if (bus.rd)
        begin
            if (bus.addr == dcs_pkg::OFS_MAIN)
                s_d.rdata = s_q.mainCtl;
            else if (bus.addr == dcs_pkg::OFS_PARITY)
                s_d.rdata = s_q.parity;
            else if (bus.addr == dcs_pkg::OFS_SHUTOFF)
                s_d.rdata = s_q.shutoff;
            else if (bus.addr == dcs_pkg::OFS_CURRENT)
                s_d.rdata = s_q.current;
            else if (bus.addr == dcs_pkg::OFS_PATTERN)
                s_d.rdata = patternResults;
            else if (bus.addr == dcs_pkg::OFS_ALARM)
                s_d.rdata = alarmFlags;
            else if (bus.addr == dcs_pkg::OFS_TEMP)
                s_d.rdata = {tempData, 8'h00};
            else if (bus.addr == dcs_pkg::OFS_PLL)
                s_d.rdata = {s_q.pll[15:3], loopFilterVolt};
            else if (bus.addr == dcs_pkg::OFS_VCO)
                s_d.rdata = s_q.vco;
            else if (bus.addr == dcs_pkg::OFS_REFSEL)
                s_d.rdata = s_q.refSel;
            else if (bus.addr == dcs_pkg::OFS_CORRSYNC)
                s_d.rdata = s_q.corrSrc;
            else if (bus.addr == dcs_pkg::OFS_MIXSYNC)
                s_d.rdata = s_q.mixSrc;
            else if (bus.addr == dcs_pkg::OFS_FIFOSYNC)
                s_d.rdata = s_q.fifoSrc;
            else if (bus.addr == dcs_pkg::OFS_IRQSTAT)
                s_d.rdata = {12'h000, s_q.irqStat};
            else if (bus.addr == dcs_pkg::OFS_IRQMASK)
                s_d.rdata = {12'h000, s_q.irqMask};
            else
                s_d.rdata = '0;
        end

        // FIFO input pointer from input strobe
        s_d.sync.fifoInPtrSync = pinRise[4]
            && s_q.fifoSrc[dcs_pkg::MSB_FIFO_ISRC:dcs_pkg::LSB_FIFO_ISRC] == dcs_pkg::SRC_INSTR;
        // Output pointer and divider from output strobe
        s_d.sync.fifoOutPtrSync = pinRise[3]
            && s_q.fifoSrc[dcs_pkg::MSB_FIFO_OSRC:dcs_pkg::LSB_FIFO_OSRC] == dcs_pkg::SRC_OUTSTR;
        // Divider nibble of zero follows the output strobe; main control bit gates it
        s_d.sync.clkDivSync = pinRise[3] && s_q.mainCtl[dcs_pkg::BIT_DIVSYNC_EN]
            && s_q.fifoSrc[dcs_pkg::MSB_DIV_SRC:dcs_pkg::LSB_DIV_SRC] == dcs_pkg::SRC_DIV_OUTPUT_STROBE;
        s_d.sync.pllDivSync = pinRise[2] && s_q.pll[dcs_pkg::BIT_PLL_NDIVSYNC];
        // Mixer and accumulator from sync pin pair
        s_d.sync.mixerSync = pinRise[2]
            && s_q.mixSrc[15:12] == dcs_pkg::SRC_SYNCPIN
            && s_q.mixSrc[11:8] == dcs_pkg::SRC_SYNCPIN;
        s_d.sync.ncoAccSync = pinRise[2]
            && s_q.mixSrc[7:4] == dcs_pkg::SRC_SYNCPIN;
        // Correction sync: soft trigger or auto write
        s_d.sync.corrSync = (sifSyncRise && s_q.corrSrc[15:12] != 4'h0)
            || (autoWrite && s_q.corrSrc[3:0] != 4'h0);
        // Either gate source enables transmit
        s_d.sync.txEnable = pinLevel[0] || s_q.current[dcs_pkg::BIT_SIF_TX];

        // Interrupt events; set wins over write-one clear
        irqEvt = '0;
        irqEvt[dcs_pkg::IRQ_ALARM] = |(alarmEvents & dcs_pkg::ALM_IMPL);
        irqEvt[dcs_pkg::IRQ_SYNC] = pinRise[2] || pinRise[1];
        irqEvt[dcs_pkg::IRQ_CORR] = s_d.sync.corrSync;
        irqEvt[dcs_pkg::IRQ_TX] = s_d.sync.txEnable && !s_q.sync.txEnable;
        if (bus.wr && bus.addr == dcs_pkg::OFS_IRQSTAT)
            s_d.irqStat = s_q.irqStat & ~bus.wdata[dcs_pkg::NIRQ-1:0];
        s_d.irqStat = s_d.irqStat | irqEvt;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q <= '0;
            s_q.mainCtl <= dcs_pkg::RST_MAIN;
            s_q.parity <= dcs_pkg::RST_PARITY;
            s_q.shutoff <= dcs_pkg::RST_SHUTOFF;
            s_q.current <= dcs_pkg::RST_CURRENT;
        end
        else
            s_q <= s_d;
    end

    assign rdata = s_q.rdata;
    assign syncOut = s_q.sync;
    assign mainCtrl = s_q.mainCtl;
    assign vcoTune = s_q.vco;
    assign irq = |(s_q.irqStat & s_q.irqMask);
endmodule // dcs_config_sync_sequencer

/* dcs_config_sync_sequencer_monitor.sv */
`timescale 1ns/1ps
module dcs_config_sync_sequencer_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire dcs_pkg::dcs_bus_t bus,
    input wire logic [dcs_pkg::DW-1:0] rdata,
    input wire dcs_pkg::dcs_pins_t pins,
    input wire logic [dcs_pkg::DW-1:0] alarmEvents,
    input wire logic [dcs_pkg::DW-1:0] patternResults,
    input wire logic [7:0] tempData,
    input wire logic [2:0] loopFilterVolt,
    input wire dcs_pkg::dcs_sync_t syncOut,
    input wire logic [dcs_pkg::DW-1:0] mainCtrl,
    input wire logic [dcs_pkg::DW-1:0] vcoTune,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic corrEn_q;
    logic softBit_q;
    // Shadow of the soft sync arming, so a repeated set is not taken for a new event
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            corrEn_q <= 1'b0;
            softBit_q <= 1'b0;
        end
        else if (bus.wr && bus.addr == dcs_pkg::OFS_CORRSYNC)
            corrEn_q <= bus.wdata[15:12] != 4'h0;
        else if (bus.wr && bus.addr == dcs_pkg::OFS_MIXSYNC)
            softBit_q <= bus.wdata[1];
    end
    sequence s_alarm_read;
        alarmEvents[dcs_pkg::ALM_PLL] ##1 !(bus.wr && bus.addr == dcs_pkg::OFS_ALARM) [*2]
            ##0 bus.rd && bus.addr == dcs_pkg::OFS_ALARM;
    endsequence
    sequence s_clear_read;
        bus.wr && bus.addr == dcs_pkg::OFS_ALARM && bus.wdata == 16'h0000 && alarmEvents == 16'h0000
            ##1 alarmEvents == 16'h0000 && !bus.wr ##1 bus.rd && bus.addr == dcs_pkg::OFS_ALARM;
    endsequence
    a_alarm_sticky: assert property (s_alarm_read |=> rdata[dcs_pkg::ALM_PLL])
        else $error("alarm flag lost before clear");
    a_alarm_clear: assert property (s_clear_read |=> rdata == 16'h0000)
        else $error("alarm flags not cleared");
    a_pattern_read: assert property (
        bus.rd && bus.addr == dcs_pkg::OFS_PATTERN |=> rdata == $past(patternResults))
        else $error("pattern read mismatch");
    a_temp_read: assert property (
        bus.rd && bus.addr == dcs_pkg::OFS_TEMP |=> rdata[15:8] == $past(tempData))
        else $error("temperature read mismatch");
    a_main_write: assert property (
        bus.wr && bus.addr == dcs_pkg::OFS_MAIN |=> mainCtrl == $past(bus.wdata))
        else $error("main control not written");
    a_vco_write: assert property (
        bus.wr && bus.addr == dcs_pkg::OFS_VCO |=> vcoTune == $past(bus.wdata))
        else $error("tune register not written");
    a_soft_sync: assert property (
        bus.wr && bus.addr == dcs_pkg::OFS_MIXSYNC && bus.wdata[1] && !softBit_q && corrEn_q
        |=> syncOut.corrSync) else $error("soft sync missing");
    a_tx_gate: assert property (pins.txGatePin [*4] |-> syncOut.txEnable)
        else $error("transmit not enabled by gate pin");
    a_reset_state: assert property ($rose(rstn) |-> mainCtrl == dcs_pkg::RST_MAIN && !irq)
        else $error("bad state after reset");
endmodule // dcs_config_sync_sequencer_monitor

/* dcs_config_sync_sequencer_tb_top.sv */
`timescale 1ns/1ps
module dcs_config_sync_sequencer_tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    dcs_pkg::dcs_bus_t bus = '0;
    logic [15:0] rdata;
    dcs_pkg::dcs_pins_t pins;
    logic [15:0] alarmEvents = 16'h0000;
    logic [15:0] patternResults = 16'h5a3c;
    logic [7:0] tempData = 8'h2b;
    logic [2:0] loopFilterVolt = 3'h5;
    dcs_pkg::dcs_sync_t syncOut;
    logic [15:0] mainCtrl;
    logic [15:0] vcoTune;
    logic irq;
    logic [3:0] pulseReq = 4'h0;
    logic gateReq = 1'b0;
    logic clrSeen = 1'b0;
    logic [7:0] seen = 8'h00;
    logic [15:0] d;
    int n_errors = 0;
    int checked = 0;
    always #10 clk = ~clk;
    // Sync outputs other than txEnable are one-cycle pulses, so collect them
    always @(posedge clk) seen <= clrSeen ? 8'h00 : seen | syncOut;
    dcs_config_sync_sequencer i_dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .pins(pins), .alarmEvents(alarmEvents), .patternResults(patternResults),
        .tempData(tempData), .loopFilterVolt(loopFilterVolt), .syncOut(syncOut),
        .mainCtrl(mainCtrl), .vcoTune(vcoTune), .irq(irq));
    dcs_host_pins i_host (.clk(clk), .pulseReq(pulseReq), .gateReq(gateReq), .pins(pins));
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task rchk(input string n, input logic [5:0] a, input logic [15:0] e);
        rd(a);
        chk(n, e, d);
    endtask
    task look(input logic [7:0] e);
        repeat (8) @(posedge clk);
        chk("sync pulses", {8'h00, e}, {8'h00, seen & 8'hfe});
    endtask
    task pin(input logic [3:0] req, input logic [7:0] e);
        @(posedge clk);
        clrSeen <= 1'b1;
        pulseReq <= req;
        @(posedge clk);
        clrSeen <= 1'b0;
        pulseReq <= 4'h0;
        look(e);
    endtask
    task end_sim;
        $display("Comparisons %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk("main", 6'h00, dcs_pkg::RST_MAIN);
        rchk("parity", 6'h01, dcs_pkg::RST_PARITY);
        rchk("shutoff", 6'h02, dcs_pkg::RST_SHUTOFF);
        rchk("current", 6'h03, dcs_pkg::RST_CURRENT);
        rchk("alarm", 6'h05, 16'h0000);
        rchk("unmapped", 6'h3f, 16'h0000);
        wr(6'h00, 16'hf29f);
        wr(6'h1a, 16'h9000);
        rchk("vco", 6'h1a, 16'h9000);
        chk("vco port", 16'h9000, vcoTune);
        wr(6'h18, 16'h2c58);
        wr(6'h1e, 16'h9999);
        wr(6'h1f, 16'h4440);
        wr(6'h20, 16'h2400);
        pin(4'h8, 8'h80);
        pin(4'h4, 8'h60);
        pin(4'h2, 8'h1c);
        pin(4'h1, 8'h00);
        rd(6'h18);
        chk("loop volt", 16'h0005, {13'h0000, d[2:0]});
        wr(6'h30, 16'h000f);
        @(posedge clk);
        alarmEvents <= 16'hffff;
        @(posedge clk);
        alarmEvents <= 16'h0000;
        rchk("alarm all", 6'h05, dcs_pkg::ALM_IMPL);
        rchk("irq stat", 6'h30, 16'h0001);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(6'h05, 16'h1234);
        rchk("alarm kept", 6'h05, dcs_pkg::ALM_IMPL);
        wr(6'h05, 16'h0000);
        rchk("alarm clr", 6'h05, 16'h0000);
        rchk("alarm recheck", 6'h05, 16'h0000);
        wr(6'h31, 16'h0001);
        rchk("irq mask", 6'h31, 16'h0001);
        chk("irq on", 16'h0001, {15'h0000, irq});
        wr(6'h30, 16'h0001);
        rchk("irq clr", 6'h30, 16'h0000);
        chk("irq off", 16'h0000, {15'h0000, irq});
        pin(4'h0, 8'h00);
        wr(6'h10, 16'h0123);
        look(8'h02);
        pin(4'h0, 8'h00);
        wr(6'h1f, 16'h4442);
        look(8'h02);
        pin(4'h0, 8'h00);
        wr(6'h1f, 16'h4442);
        look(8'h00);
        wr(6'h1f, 16'h4448);
        wr(6'h1f, 16'h4442);
        look(8'h02);
        wr(6'h00, 16'hf29b);
        rchk("main", 6'h00, 16'hf29b);
        chk("main port", 16'hf29b, mainCtrl);
        wr(6'h20, 16'h0000);
        pin(4'h8, 8'h00);
        pin(4'h4, 8'h00);
        wr(6'h18, 16'h2458);
        pin(4'h2, 8'h0c);
        wr(6'h04, 16'hffff);
        rchk("pattern", 6'h04, 16'h5a3c);
        wr(6'h06, 16'hffff);
        rd(6'h06);
        chk("temp", 16'h002b, {8'h00, d[15:8]});
        @(posedge clk);
        gateReq <= 1'b1;
        repeat (6) @(posedge clk);
        chk("tx pin", 16'h0001, {15'h0000, syncOut.txEnable});
        gateReq <= 1'b0;
        repeat (6) @(posedge clk);
        chk("tx off", 16'h0000, {15'h0000, syncOut.txEnable});
        wr(6'h03, 16'hf001);
        repeat (3) @(posedge clk);
        chk("tx bit", 16'h0001, {15'h0000, syncOut.txEnable});
        rchk("irq events", 6'h30, 16'h000e);
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim;
    end
endmodule // dcs_config_sync_sequencer_tb_top
bind dcs_config_sync_sequencer dcs_config_sync_sequencer_monitor i_mon (.clk(clk),
    .rstn(rstn), .bus(bus), .rdata(rdata), .pins(pins), .alarmEvents(alarmEvents),
    .patternResults(patternResults), .tempData(tempData), .loopFilterVolt(loopFilterVolt),
    .syncOut(syncOut), .mainCtrl(mainCtrl), .vcoTune(vcoTune), .irq(irq));

/* dcs_host_pins.sv */
`timescale 1ns/1ps
module dcs_host_pins (
    input wire logic clk,
    input wire logic [3:0] pulseReq,
    input wire logic gateReq,
    output dcs_pkg::dcs_pins_t pins
);
    logic [3:0] p1_q = 4'h0;
    logic [3:0] p2_q = 4'h0;
    logic [3:0] p3_q = 4'h0;
    // Held three clocks so the synchroniser sees a clean rising edge
    always @(posedge clk)
    begin
        p1_q <= pulseReq;
        p2_q <= p1_q;
        p3_q <= p2_q;
    end
    assign pins = dcs_pkg::dcs_pins_t'({p1_q | p2_q | p3_q, gateReq});
endmodule // dcs_host_pins

/* dcs_pkg.sv */
package dcs_pkg;

    localparam int AW = 6;
    localparam int DW = 16;

    // Register offsets
    localparam logic [5:0] OFS_MAIN = 6'h00;
    localparam logic [5:0] OFS_PARITY = 6'h01;
    localparam logic [5:0] OFS_SHUTOFF = 6'h02;
    localparam logic [5:0] OFS_CURRENT = 6'h03;
    localparam logic [5:0] OFS_PATTERN = 6'h04;
    localparam logic [5:0] OFS_ALARM = 6'h05;
    localparam logic [5:0] OFS_TEMP = 6'h06;
    localparam logic [5:0] OFS_PLL = 6'h18;
    localparam logic [5:0] OFS_VCO = 6'h1a;
    localparam logic [5:0] OFS_REFSEL = 6'h1b;
    localparam logic [5:0] OFS_CORRSYNC = 6'h1e;
    localparam logic [5:0] OFS_MIXSYNC = 6'h1f;
    localparam logic [5:0] OFS_FIFOSYNC = 6'h20;
    localparam logic [5:0] OFS_IRQSTAT = 6'h30;
    localparam logic [5:0] OFS_IRQMASK = 6'h31;
    localparam logic [5:0] OFS_AUTO_FIRST = 6'h08;
    localparam logic [5:0] OFS_AUTO_LAST = 6'h13;

    // Reset values
    localparam logic [15:0] RST_MAIN = 16'h049c;
    localparam logic [15:0] RST_PARITY = 16'h050e;
    localparam logic [15:0] RST_SHUTOFF = 16'h7000;
    localparam logic [15:0] RST_CURRENT = 16'hf000;
    localparam logic [15:0] RST_ZERO = 16'h0000;

    // Field positions
    localparam int BIT_DIVSYNC_EN = 2;
    localparam int BIT_SIF_TX = 0;
    localparam int BIT_SIF_SYNC = 1;
    localparam int BIT_PLL_NDIVSYNC = 11;
    localparam int LSB_LFVOLT = 0;
    localparam int MSB_LFVOLT = 2;
    localparam int LSB_VCO = 10;
    localparam int MSB_VCO = 15;
    localparam int LSB_FIFO_ISRC = 12;
    localparam int MSB_FIFO_ISRC = 15;
    localparam int LSB_FIFO_OSRC = 8;
    localparam int MSB_FIFO_OSRC = 11;
    localparam int LSB_DIV_SRC = 4;
    localparam int MSB_DIV_SRC = 7;
    localparam int LSB_MIX_SRC = 4;
    localparam int MSB_MIX_SRC = 15;

    // Alarm bit positions
    localparam int ALM_ZEROCHK = 15;
    localparam int ALM_FIFO_LSB = 10;
    localparam int ALM_DACCLK = 9;
    localparam int ALM_DATACLK = 8;
    localparam int ALM_OUTPUT = 7;
    localparam int ALM_IOTEST = 6;
    localparam int ALM_PLL = 4;
    localparam int ALM_RPARITY = 3;
    localparam int ALM_FPARITY = 2;
    localparam int ALM_FRAME = 1;
    localparam logic [15:0] ALM_IMPL = 16'h9fde;

    // Sync source encodings (per 4-bit nibble)
    localparam logic [3:0] SRC_INSTR = 4'h2;
    localparam logic [3:0] SRC_OUTSTR = 4'h4;
    localparam logic [3:0] SRC_SYNCPIN = 4'h4;
    localparam logic [3:0] SRC_SIFSYNC = 4'h8;
    localparam logic [3:0] SRC_AUTO = 4'h1;
    localparam logic [3:0] SRC_DIV_OUTPUT_STROBE = 4'h0;

    // Interrupt status bits
    localparam int NIRQ = 4;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_SYNC = 1;
    localparam int IRQ_CORR = 2;
    localparam int IRQ_TX = 3;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } dcs_bus_t;

    typedef struct packed {
        logic inputStrobe;
        logic outputStrobe;
        logic syncPinPair;
        logic framePinPair;
        logic txGatePin;
    } dcs_pins_t;

    typedef struct packed {
        logic fifoInPtrSync;
        logic fifoOutPtrSync;
        logic clkDivSync;
        logic pllDivSync;
        logic mixerSync;
        logic ncoAccSync;
        logic corrSync;
        logic txEnable;
    } dcs_sync_t;

endpackage

/* dcs_sticky.sv */
`timescale 1ns/1ps
// Sticky flag bank; set wins over clear in the same cycle
module dcs_sticky #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] setBits,
    input wire logic [W-1:0] clrBits,
    output logic [W-1:0] flags
);
    typedef struct packed {
        logic [W-1:0] f;
    } dcs_stk_t;

    dcs_stk_t s_q;
    dcs_stk_t s_d;

    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < W; i++)
        begin
            s_d.f[i] = setBits[i] | (s_q.f[i] & ~clrBits[i]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign flags = s_q.f;
endmodule // dcs_sticky

/* dcs_sync_in.sv */
`timescale 1ns/1ps
// Two-flop synchroniser with rising edge detect on the second stage
module dcs_sync_in #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] last;
    } dcs_sin_t;

    dcs_sin_t s_q;
    dcs_sin_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.meta = pinIn;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level = s_q.sync;
    assign rise = s_q.sync & ~s_q.last;
endmodule // dcs_sync_in
